// ==== hocs_feed.sv ====
`timescale 1ns/1ns
`default_nettype none
module hocs_feed
	import hocs_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic [2:0]  ch,
	input  wire logic [3:0]  hidx,
	input  wire logic [15:0] mag,
	input  wire logic [15:0] fund,
	input  wire logic        blk,
	output var  hocs_meas_t  meas,
	output logic             block_in
);
	// Unselected slots read zero so only one slot can pick up
	always_ff @(posedge mclk) begin
		for (int c = 0; c < NUM_CHAN; c++) begin
			meas[c].fund <= fund;
			for (int h = 0; h < NUM_HARM; h++) begin
				meas[c].harm[h] <= (3'(c) == ch && 4'(h) == hidx) ? mag : 16'h0000;
			end
		end
	end
	always_ff @(posedge mclk) begin
		block_in <= blk;
	end
endmodule
`default_nettype wire

// ==== hocs_pkg.sv ====
// How it works
// - Forced status honoured only with forcing enabled
// - One selectable harmonic, second by default
// - Per unit or relative mode, per unit default
// - Phase trio or either residual input
// - Each instance owns its settings, runs alone
// - Common threshold, any phase exceeding picks up
// - Drop-out below 97 percent of threshold
// - Per unit threshold, 0.01 steps, 0.20 default
// - Relative threshold, 0.01 percent, 20 percent default
// - Start only while blocking inactive
// - Blocking sampled at each program cycle start
// - Blocked at pick-up: blocked output, nothing more
// - Blocking during start: release as drop-out
// - Blocked output gives notification and stamped event
// - Software switch drives blocking while forcing
// - Condition readback: normal, start, trip, blocked
// - Ratio readback in hundredths
// - Expected operating time readback, 5 ms steps
// - Signed remaining time while counting, 5 ms steps
// - On and off events, 1 ms time stamps
// - 20 ms averaged history for pre-fault values
package hocs_pkg;

	localparam int unsigned CLK_HZ       = 250_000_000;
	localparam int unsigned PROG_MS      = 5;
	localparam int unsigned PROG_CYCLES  = CLK_HZ / 1000 * PROG_MS;
	localparam int unsigned STAMP_MS     = 1;
	localparam int unsigned STAMP_CYCLES = CLK_HZ / 1000 * STAMP_MS;
	localparam int unsigned HIST_MS      = 20;
	localparam int unsigned HIST_DEPTH   = HIST_MS / PROG_MS;
	localparam int unsigned NUM_HARM     = 12;
	localparam int unsigned NUM_CHAN     = 5;
	localparam int unsigned NUM_EV       = 6;
	localparam int unsigned DIV_STEPS    = 56;

	localparam logic [7:0]  RESET_RATIO_PCT = 8'h61;
	localparam logic [7:0]  RATIO_SCALE     = 8'h64;
	localparam logic [15:0] REL_FULL        = 16'h2710;
	localparam logic [31:0] RATIO_MAX       = 32'h0098_9680;

	localparam logic [7:0] ADDR_CFG      = 8'h00;
	localparam logic [7:0] ADDR_PU_THR   = 8'h04;
	localparam logic [7:0] ADDR_REL_THR  = 8'h08;
	localparam logic [7:0] ADDR_OP_DLY   = 8'h0C;
	localparam logic [7:0] ADDR_RLS_DLY  = 8'h10;
	localparam logic [7:0] ADDR_STATUS   = 8'h14;
	localparam logic [7:0] ADDR_RATIO    = 8'h18;
	localparam logic [7:0] ADDR_EXP_TIME = 8'h1C;
	localparam logic [7:0] ADDR_REMAIN   = 8'h20;
	localparam logic [7:0] ADDR_PRE_L1   = 8'h24;
	localparam logic [7:0] ADDR_PRE_L2   = 8'h28;
	localparam logic [7:0] ADDR_PRE_L3   = 8'h2C;

	localparam int unsigned CFG_HSEL_LSB  = 0;
	localparam int unsigned CFG_MODE_BIT  = 4;
	localparam int unsigned CFG_SRC_LSB   = 5;
	localparam int unsigned CFG_FORCE_LSB = 8;
	localparam int unsigned CFG_SWBLK_BIT = 10;

	localparam int unsigned ST_COND_LSB    = 0;
	localparam int unsigned ST_START_BIT   = 2;
	localparam int unsigned ST_TRIP_BIT    = 3;
	localparam int unsigned ST_BLOCKED_BIT = 4;
	localparam int unsigned ST_PICKUP_BIT  = 5;
	localparam int unsigned ST_BLKIN_BIT   = 6;

	localparam logic [3:0]  HSEL_RST    = 4'h0;
	localparam logic        MODE_RST    = 1'b0;
	localparam logic [1:0]  SRC_RST     = 2'h0;
	localparam logic [1:0]  FORCE_RST   = 2'h0;
	localparam logic [15:0] PU_THR_RST  = 16'h0014;
	localparam logic [15:0] REL_THR_RST = 16'h07D0;
	localparam logic [15:0] OP_DLY_RST  = 16'h0014;
	localparam logic [15:0] RLS_DLY_RST = 16'h0000;

	localparam logic [1:0] COND_NORMAL  = 2'h0;
	localparam logic [1:0] COND_START   = 2'h1;
	localparam logic [1:0] COND_TRIP    = 2'h2;
	localparam logic [1:0] COND_BLOCKED = 2'h3;

	localparam logic MODE_PU = 1'b0;
	localparam logic [1:0] SRC_PHASE = 2'h0;
	localparam logic [1:0] SRC_RES1  = 2'h1;
	localparam int unsigned CH_RES1 = 3;
	localparam int unsigned CH_RES2 = 4;

	localparam logic [2:0] EV_START_ON  = 3'h0;
	localparam logic [2:0] EV_START_OFF = 3'h1;
	localparam logic [2:0] EV_TRIP_ON   = 3'h2;
	localparam logic [2:0] EV_TRIP_OFF  = 3'h3;
	localparam logic [2:0] EV_BLOCK_ON  = 3'h4;
	localparam logic [2:0] EV_BLOCK_OFF = 3'h5;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [15:0]                fund;
		logic [NUM_HARM-1:0][15:0]  harm;
	} hocs_chan_t;

	typedef hocs_chan_t [NUM_CHAN-1:0] hocs_meas_t;

	typedef struct packed {
		logic [2:0]       kind;
		logic [31:0]      stamp;
		logic [2:0]       fault;
		logic [2:0][15:0] cur;
		logic [2:0][15:0] pre;
	} hocs_event_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RUN,
		ST_TRIP,
		ST_BLOCK,
		ST_RELEASE
	} hocs_state_t;

endpackage

// ==== hocs_stage.sv ====
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module hocs_stage
	import hocs_pkg::*;
#(
	parameter int unsigned PROG_LEN  = PROG_CYCLES,
	parameter int unsigned STAMP_LEN = STAMP_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire hocs_meas_t  meas,
	input  wire logic        block_in,
	input  wire logic        stage_force_en,
	output logic             start,
	output logic             trip,
	output logic             blocked,
	output logic             notify,
	output logic             evt_valid,
	output hocs_event_t      evt
);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [47:0] scaled_meas(input logic [15:0] h, input logic mode);
		return (mode == MODE_PU) ? 48'(h) : 48'(h) * 48'(REL_FULL);
	endfunction

	function automatic logic [47:0] scaled_thr(input logic [15:0] pu, input logic [15:0] rel,
		input logic [15:0] fund, input logic mode);
		return (mode == MODE_PU) ? 48'(pu) : 48'(rel) * 48'(fund);
	endfunction

	function automatic logic [2:0] first_bit(input logic [NUM_EV-1:0] m);
		logic [2:0] r;
		r = 3'h0;
		for (int i = NUM_EV - 1; i >= 0; i--) begin
			if (m[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	// Settings, one private copy per instance
	logic [3:0]  hsel_q;
	logic        mode_q;
	logic [1:0]  src_q;
	logic [1:0]  force_q;
	logic        swblk_q;
	logic [15:0] pu_thr_q;
	logic [15:0] rel_thr_q;
	logic [15:0] op_dly_q;
	logic [15:0] rls_dly_q;

	logic [31:0] prog_cnt_q;
	logic [31:0] stamp_cnt_q;
	logic [31:0] stamp_q;
	logic        prog_tick;

	assign prog_tick = prog_cnt_q == 32'(PROG_LEN - 1);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prog_cnt_q  <= 32'h0000_0000;
			stamp_cnt_q <= 32'h0000_0000;
			stamp_q     <= 32'h0000_0000;
		end else begin
			prog_cnt_q <= prog_tick ? 32'h0000_0000 : prog_cnt_q + 32'h0000_0001;
			if (stamp_cnt_q == 32'(STAMP_LEN - 1)) begin
				stamp_cnt_q <= 32'h0000_0000;
				stamp_q     <= stamp_q + 32'h0000_0001;
			end else begin
				stamp_cnt_q <= stamp_cnt_q + 32'h0000_0001;
			end
		end
	end

	logic [2:0][15:0] harm_s;
	logic [2:0][47:0] lhs;
	logic [2:0][47:0] rhs;
	logic [2:0]       over;
	logic [2:0]       under;
	logic [47:0]      mx_lhs;
	logic [47:0]      mx_rhs;
	logic             pick_q;
	logic             pick_d;
	logic             blk_src;

	always_comb begin
		hocs_chan_t ch;
		logic [3:0] hs;
		ch     = '0;
		hs     = (32'(hsel_q) < NUM_HARM) ? hsel_q : HSEL_RST;
		mx_lhs = 48'h0000_0000_0000;
		mx_rhs = 48'h0000_0000_0000;
		for (int i = 0; i < 3; i++) begin
			if (src_q == SRC_PHASE) begin
				ch = meas[i];
			end else if (i == 0) begin
				ch = (src_q == SRC_RES1) ? meas[CH_RES1] : meas[CH_RES2];
			end else begin
				ch = '0;
			end
			harm_s[i] = ch.harm[hs];
			lhs[i] = scaled_meas(harm_s[i], mode_q);
			rhs[i] = scaled_thr(pu_thr_q, rel_thr_q, ch.fund, mode_q);
			over[i] = (src_q == SRC_PHASE || i == 0) && lhs[i] > rhs[i];
			under[i] = (src_q != SRC_PHASE && i != 0) ||
				(56'(lhs[i]) * 56'(RATIO_SCALE)) < (56'(rhs[i]) * 56'(RESET_RATIO_PCT));
			if (lhs[i] >= mx_lhs) begin
				mx_lhs = lhs[i];
				mx_rhs = rhs[i];
			end
		end
	end

	assign pick_d = (|over) | (pick_q & ~(&under));
	assign blk_src = block_in | (stage_force_en & swblk_q);

	hocs_state_t state_q;
	logic        blk_q;
	logic [15:0] timer_q;
	logic [15:0] rls_q;
	logic [2:0]  fault_q;
	logic [2:0][15:0] cur_q;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			pick_q  <= 1'b0;
			blk_q   <= 1'b0;
			timer_q <= 16'h0000;
			rls_q   <= 16'h0000;
			fault_q <= 3'h0;
			cur_q   <= '0;
		end else if (prog_tick) begin
			blk_q   <= blk_src;
			pick_q  <= pick_d;
			fault_q <= over;
			cur_q   <= harm_s;
			case (state_q)
				ST_IDLE: begin
					timer_q <= 16'h0000;
					if (pick_d) begin
						state_q <= blk_src ? ST_BLOCK : ST_RUN;
					end
				end
				ST_RUN: begin
					if (blk_src || !pick_d) begin
						state_q <= ST_RELEASE;
						rls_q   <= 16'h0000;
					end else begin
						timer_q <= timer_q + 16'h0001;
						if (timer_q + 16'h0001 >= op_dly_q) begin
							state_q <= ST_TRIP;
						end
					end
				end
				ST_TRIP: begin
					if (blk_src || !pick_d) begin
						state_q <= ST_RELEASE;
						rls_q   <= 16'h0000;
					end
				end
				ST_RELEASE: begin
					if (pick_d && !blk_src) begin
						state_q <= ST_RUN;
					end else if (rls_q + 16'h0001 >= rls_dly_q) begin
						state_q <= ST_IDLE;
						timer_q <= 16'h0000;
					end else begin
						rls_q <= rls_q + 16'h0001;
					end
				end
				ST_BLOCK: begin
					if (!pick_d || !blk_src) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	logic start_d;
	logic trip_d;
	logic blocked_d;

	always_comb begin
		start_d   = state_q == ST_RUN || state_q == ST_TRIP;
		trip_d    = state_q == ST_TRIP;
		blocked_d = state_q == ST_BLOCK;
		if (stage_force_en && force_q != COND_NORMAL) begin
			start_d   = force_q == COND_START || force_q == COND_TRIP;
			trip_d    = force_q == COND_TRIP;
			blocked_d = force_q == COND_BLOCKED;
		end
	end

	logic [1:0] cond;
	assign cond = trip ? COND_TRIP : start ? COND_START : blocked ? COND_BLOCKED : COND_NORMAL;

	logic [NUM_EV-1:0] ev_set;
	logic [NUM_EV-1:0] pend_q;
	logic [2:0]        ev_sel;

	assign ev_set = {blocked & ~blocked_d, ~blocked & blocked_d, trip & ~trip_d,
		~trip & trip_d, start & ~start_d, ~start & start_d};
	assign ev_sel = first_bit(pend_q);

	logic [HIST_DEPTH-1:0][2:0][15:0] hist_q;
	logic [1:0]       hidx_q;
	logic [2:0][15:0] avg;
	logic [2:0][15:0] pre_q;

	always_comb begin
		logic [17:0] sum;
		sum = 18'h0_0000;
		for (int i = 0; i < 3; i++) begin
			sum = 18'h0_0000;
			for (int k = 0; k < int'(HIST_DEPTH); k++) begin
				sum = sum + 18'(hist_q[k][i]);
			end
			avg[i] = 16'(sum >> $clog2(HIST_DEPTH));
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hist_q <= '0;
			hidx_q <= 2'h0;
			pre_q  <= '0;
		end else begin
			if (prog_tick) begin
				hist_q[hidx_q] <= harm_s;
				hidx_q         <= hidx_q + 2'h1;
			end
			if (ev_set[EV_START_ON] || ev_set[EV_TRIP_ON]) begin
				pre_q <= avg;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			start     <= 1'b0;
			trip      <= 1'b0;
			blocked   <= 1'b0;
			pend_q    <= '0;
			evt_valid <= 1'b0;
			evt       <= '0;
			notify    <= 1'b0;
		end else begin
			start     <= start_d;
			trip      <= trip_d;
			blocked   <= blocked_d;
			evt_valid <= |pend_q;
			notify    <= 1'b0;
			// New edges win over the clear of the one sent
			pend_q <= (pend_q & ~(NUM_EV'(|pend_q) << ev_sel)) | ev_set;
			if (|pend_q) begin
				evt.kind  <= ev_sel;
				evt.stamp <= stamp_q;
				evt.fault <= fault_q;
				evt.cur   <= cur_q;
				evt.pre   <= pre_q;
				notify    <= ev_sel == EV_BLOCK_ON;
			end
		end
	end

	// Ratio divider; shift-subtract keeps area small, result lands DIV_STEPS + 2 cycles after the program tick
	logic [55:0] num_q;
	logic [47:0] den_q;
	logic [48:0] rem_q;
	logic [55:0] quo_q;
	logic [5:0]  dcnt_q;
	logic        dbusy_q;
	logic [31:0] ratio_q;
	logic [48:0] rem_t;

	assign rem_t = {rem_q[47:0], num_q[55]};

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			num_q   <= '0;
			den_q   <= '0;
			rem_q   <= '0;
			quo_q   <= '0;
			dcnt_q  <= 6'h00;
			dbusy_q <= 1'b0;
			ratio_q <= 32'h0000_0000;
		end else if (prog_tick) begin
			num_q   <= 56'(mx_lhs) * 56'(RATIO_SCALE);
			den_q   <= mx_rhs;
			rem_q   <= '0;
			quo_q   <= '0;
			dcnt_q  <= 6'(DIV_STEPS);
			dbusy_q <= 1'b1;
		end else if (dcnt_q != 6'h00) begin
			num_q  <= num_q << 1;
			dcnt_q <= dcnt_q - 6'h01;
			if (rem_t >= {1'b0, den_q}) begin
				rem_q <= rem_t - {1'b0, den_q};
				quo_q <= {quo_q[54:0], 1'b1};
			end else begin
				rem_q <= rem_t;
				quo_q <= {quo_q[54:0], 1'b0};
			end
		end else if (dbusy_q) begin
			dbusy_q <= 1'b0;
			if (den_q == 48'h0000_0000_0000 || quo_q > 56'(RATIO_MAX)) begin
				ratio_q <= RATIO_MAX;
			end else begin
				ratio_q <= quo_q[31:0];
			end
		end
	end

	logic [31:0] remain;
	assign remain = (state_q == ST_RUN) ? 32'(op_dly_q) - 32'(timer_q) : 32'h0000_0000;

	logic        aw_hold_q;
	logic [7:0]  aw_addr_q;
	logic        w_hold_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        wr_go;
	logic [7:0]  wa;
	logic [31:0] wd;
	logic [3:0]  ws;

	assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign wr_go = (aw_hold_q | (s_axi_awvalid & s_axi_awready)) &
		(w_hold_q | (s_axi_wvalid & s_axi_wready));
	assign wa = aw_hold_q ? aw_addr_q : s_axi_awaddr;
	assign wd = w_hold_q ? w_data_q : s_axi_wdata;
	assign ws = w_hold_q ? w_strb_q : s_axi_wstrb;

	logic [31:0] cfg_rd;
	assign cfg_rd = {21'h00_0000, swblk_q, force_q, 1'b0, src_q, mode_q, hsel_q};

	logic [31:0] rd_word;
	logic        rd_ok;

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		if (s_axi_araddr == ADDR_CFG) begin
			rd_word = cfg_rd;
		end else if (s_axi_araddr == ADDR_PU_THR) begin
			rd_word = 32'(pu_thr_q);
		end else if (s_axi_araddr == ADDR_REL_THR) begin
			rd_word = 32'(rel_thr_q);
		end else if (s_axi_araddr == ADDR_OP_DLY) begin
			rd_word = 32'(op_dly_q);
		end else if (s_axi_araddr == ADDR_RLS_DLY) begin
			rd_word = 32'(rls_dly_q);
		end else if (s_axi_araddr == ADDR_STATUS) begin
			rd_word[ST_COND_LSB +: 2]  = cond;
			rd_word[ST_START_BIT]      = start;
			rd_word[ST_TRIP_BIT]       = trip;
			rd_word[ST_BLOCKED_BIT]    = blocked;
			rd_word[ST_PICKUP_BIT]     = pick_q;
			rd_word[ST_BLKIN_BIT]      = blk_q;
		end else if (s_axi_araddr == ADDR_RATIO) begin
			rd_word = ratio_q;
		end else if (s_axi_araddr == ADDR_EXP_TIME) begin
			rd_word = 32'(op_dly_q);
		end else if (s_axi_araddr == ADDR_REMAIN) begin
			rd_word = remain;
		end else if (s_axi_araddr == ADDR_PRE_L1) begin
			rd_word = 32'(pre_q[0]);
		end else if (s_axi_araddr == ADDR_PRE_L2) begin
			rd_word = 32'(pre_q[1]);
		end else if (s_axi_araddr == ADDR_PRE_L3) begin
			rd_word = 32'(pre_q[2]);
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			aw_hold_q    <= 1'b0;
			aw_addr_q    <= 8'h00;
			w_hold_q     <= 1'b0;
			w_data_q     <= 32'h0000_0000;
			w_strb_q     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else begin
			if (wr_go) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wa == ADDR_CFG || wa == ADDR_PU_THR || wa == ADDR_REL_THR ||
					wa == ADDR_OP_DLY || wa == ADDR_RLS_DLY) ? RESP_OKAY : RESP_SLVERR;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_hold_q <= 1'b1;
					aw_addr_q <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_hold_q <= 1'b1;
					w_data_q <= s_axi_wdata;
					w_strb_q <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	logic [31:0] cfg_new;
	logic [31:0] pu_new;
	logic [31:0] rel_new;
	logic [31:0] op_new;
	logic [31:0] rls_new;

	assign cfg_new = merge(cfg_rd, wd, ws);
	assign pu_new  = merge(32'(pu_thr_q), wd, ws);
	assign rel_new = merge(32'(rel_thr_q), wd, ws);
	assign op_new  = merge(32'(op_dly_q), wd, ws);
	assign rls_new = merge(32'(rls_dly_q), wd, ws);

	// Settings written only through this instance
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hsel_q    <= HSEL_RST;
			mode_q    <= MODE_RST;
			src_q     <= SRC_RST;
			force_q   <= FORCE_RST;
			swblk_q   <= 1'b0;
			pu_thr_q  <= PU_THR_RST;
			rel_thr_q <= REL_THR_RST;
			op_dly_q  <= OP_DLY_RST;
			rls_dly_q <= RLS_DLY_RST;
		end else if (wr_go) begin
			if (wa == ADDR_CFG) begin
				hsel_q  <= cfg_new[CFG_HSEL_LSB +: 4];
				mode_q  <= cfg_new[CFG_MODE_BIT];
				src_q   <= cfg_new[CFG_SRC_LSB +: 2];
				force_q <= cfg_new[CFG_FORCE_LSB +: 2];
				swblk_q <= cfg_new[CFG_SWBLK_BIT];
			end else if (wa == ADDR_PU_THR) begin
				pu_thr_q <= pu_new[15:0];
			end else if (wa == ADDR_REL_THR) begin
				rel_thr_q <= rel_new[15:0];
			end else if (wa == ADDR_OP_DLY) begin
				op_dly_q <= op_new[15:0];
			end else if (wa == ADDR_RLS_DLY) begin
				rls_dly_q <= rls_new[15:0];
			end
		end
	end

endmodule
`default_nettype wire

// ==== hocs_stage_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module hocs_stage_asserts
	import hocs_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        stage_force_en,
	input wire logic        start,
	input wire logic        trip,
	input wire logic        blocked,
	input wire logic        notify,
	input wire logic        evt_valid,
	input wire hocs_event_t evt
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// Event queue may hold lower kinds ahead of block on
	sequence s_blk_note;
		##[1:6] notify;
	endsequence
	sequence s_start_note;
		##1 (evt_valid && evt.kind == EV_START_ON);
	endsequence

	a_start_unblocked: assert property (
		(start && !stage_force_en) |-> !blocked) else $error("start with blocked");
	a_trip_with_start: assert property (trip |-> start)
		else $error("trip without start");
	a_notify_is_event: assert property (
		notify |-> (evt_valid && evt.kind == EV_BLOCK_ON)) else $error("notify no event");
	a_block_notify: assert property (
		($rose(blocked) && !stage_force_en) |-> s_blk_note) else $error("block no notify");
	a_start_event: assert property (
		($rose(start) && !stage_force_en) |-> s_start_note) else $error("start no event");
	a_write_answer: assert property (
		(s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |=> s_axi_bvalid)
		else $error("write not answered");
	a_bvalid_clear: assert property ((s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
		else $error("bvalid stuck");
	a_read_answer: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
		else $error("read not answered");
	a_rvalid_clear: assert property ((s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
		else $error("rvalid stuck");
endmodule
bind hocs_stage hocs_stage_asserts hocs_stage_asserts_inst (
	.mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .stage_force_en, .start, .trip, .blocked, .notify, .evt_valid, .evt
);
`default_nettype wire

// ==== hocs_stage_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module hocs_stage_bench
	import hocs_pkg::*;
();
	localparam int unsigned PL = 100;
	typedef struct packed {
		logic [31:0] cfg;
		logic [2:0]  ch;
		logic [3:0]  hidx;
		logic [15:0] mag;
		logic        pick;
	} hocs_row_t;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, stage_force_en = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, d;
	logic [2:0]  f_ch = 3'h7;
	logic [3:0]  f_hidx = 4'h0;
	logic [15:0] f_mag = 16'h0000;
	logic        f_blk = 1'b0, block_in, start, trip, blocked, notify, evt_valid;
	hocs_meas_t  meas;
	hocs_event_t evt;
	int          errors = 0, tests_run = 0;
	logic [15:0] blk_cur = 16'h0000;
	logic [2:0]  blk_fault = 3'h0;
	int          notes = 0;
	// Threshold 0x14; relative rows use fundamental 0x64
	hocs_row_t   rows [11] = '{
		'{32'h0000_0000, 3'h0, 4'h0, 16'h0015, 1'b1}, '{32'h0000_0000, 3'h1, 4'h0, 16'h0014, 1'b0},
		'{32'h0000_0000, 3'h2, 4'h0, 16'h0015, 1'b1}, '{32'h0000_0000, 3'h3, 4'h0, 16'h001E, 1'b0},
		'{32'h0000_0020, 3'h3, 4'h0, 16'h0015, 1'b1}, '{32'h0000_0040, 3'h4, 4'h0, 16'h0015, 1'b1},
		'{32'h0000_0040, 3'h3, 4'h0, 16'h0015, 1'b0}, '{32'h0000_0001, 3'h0, 4'h0, 16'h0032, 1'b0},
		'{32'h0000_0001, 3'h1, 4'h1, 16'h0015, 1'b1}, '{32'h0000_0010, 3'h2, 4'h0, 16'h0015, 1'b1},
		'{32'h0000_0010, 3'h0, 4'h0, 16'h0014, 1'b0}};

	always #2 mclk = ~mclk;

	// Pulses stand one cycle, so the falling edge sees each once
	always @(negedge mclk) begin
		if (evt_valid && evt.kind == EV_BLOCK_ON) begin
			blk_cur   <= evt.cur[0];
			blk_fault <= evt.fault;
		end
		if (notify) begin
			notes <= notes + 1;
		end
	end

	hocs_stage #(.PROG_LEN(PL), .STAMP_LEN(20)) hocs_stage_inst (
		.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .meas, .block_in, .stage_force_en,
		.start, .trip, .blocked, .notify, .evt_valid, .evt);
	hocs_feed hocs_feed_inst (.mclk, .ch(f_ch), .hidx(f_hidx), .mag(f_mag),
		.fund(16'h0064), .blk(f_blk), .meas, .block_in);

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			errors++;
		end
	endtask
	task automatic outs(input logic [2:0] e);
		chk("blocked_trip_start", {29'h0, e}, {29'h0, blocked, trip, start});
	endtask
	task automatic ticks(input int n);
		repeat (n * PL) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic feed(input logic [2:0] c, input logic [15:0] m, input logic b);
		@(posedge mclk);
		f_ch <= c;
		f_mag <= m;
		f_blk <= b;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		logic ah, wh, bh;
		int n;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		bh = 1'b0;
		for (n = 0; n < 50 && !bh; n++) begin
			@(negedge mclk);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bh = s_axi_bvalid;
			if (bh) chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
			@(posedge mclk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
			if (bh) s_axi_bready <= 1'b0;
		end
		if (!bh) chk("bvalid", 32'h0000_0001, 32'h0000_0000);
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
		logic ah, rh;
		int n;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		rh = 1'b0;
		v = 32'h0000_0000;
		for (n = 0; n < 50 && !rh; n++) begin
			@(negedge mclk);
			ah = s_axi_arvalid && s_axi_arready;
			rh = s_axi_rvalid;
			v = s_axi_rdata;
			if (rh) chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
			@(posedge mclk);
			if (ah) s_axi_arvalid <= 1'b0;
			if (rh) s_axi_rready <= 1'b0;
		end
		if (!rh) chk("rvalid", 32'h0000_0001, 32'h0000_0000);
	endtask
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		axi_rd(ADDR_PU_THR, RESP_OKAY, d);
		chk("pu_thr", 32'h0000_0014, d);
		axi_rd(ADDR_REL_THR, RESP_OKAY, d);
		chk("rel_thr", 32'h0000_07D0, d);
		axi_rd(8'hFC, RESP_SLVERR, d);
		chk("unmapped", 32'h0000_0000, d);
		axi_wr(ADDR_STATUS, 32'h0000_0003, RESP_SLVERR);
		foreach (rows[i]) begin
			axi_wr(ADDR_CFG, rows[i].cfg, RESP_OKAY);
			@(posedge mclk);
			f_hidx <= rows[i].hidx;
			feed(rows[i].ch, rows[i].mag, 1'b0);
			ticks(2);
			outs({2'b00, rows[i].pick});
			feed(3'h7, 16'h0000, 1'b0);
			ticks(3);
		end
		axi_wr(ADDR_CFG, 32'h0000_0000, RESP_OKAY);
		@(posedge mclk);
		f_hidx <= 4'h0;
		feed(3'h0, 16'h0028, 1'b0);
		ticks(2);
		axi_rd(ADDR_RATIO, RESP_OKAY, d);
		chk("ratio", 32'h0000_00C8, d);
		feed(3'h0, 16'h0014, 1'b0);
		ticks(2);
		outs(3'b001);
		feed(3'h0, 16'h0013, 1'b0);
		ticks(3);
		outs(3'b000);
		axi_wr(ADDR_OP_DLY, 32'h0000_0003, RESP_OKAY);
		axi_rd(ADDR_EXP_TIME, RESP_OKAY, d);
		chk("exp_time", 32'h0000_0003, d);
		feed(3'h0, 16'h0015, 1'b0);
		ticks(1);
		outs(3'b001);
		axi_rd(ADDR_REMAIN, RESP_OKAY, d);
		chk("remain", 32'h0000_0003, d);
		ticks(4);
		outs(3'b011);
		axi_rd(ADDR_STATUS, RESP_OKAY, d);
		chk("status_trip", 32'h0000_002E, d);
		// Block input lands one cycle late, so wait for the second tick
		feed(3'h0, 16'h0015, 1'b1);
		ticks(2);
		outs(3'b000);
		ticks(3);
		outs(3'b100);
		axi_rd(ADDR_STATUS, RESP_OKAY, d);
		chk("status_blk", 32'h0000_0073, d);
		chk("blk_cur", 32'h0000_0015, {16'h0000, blk_cur});
		chk("blk_fault", 32'h0000_0001, {29'h0, blk_fault});
		chk("notify", 32'h0000_0001, 32'(notes));
		feed(3'h7, 16'h0000, 1'b0);
		ticks(3);
		outs(3'b000);
		axi_wr(ADDR_CFG, 32'h0000_0200, RESP_OKAY);
		ticks(1);
		outs(3'b000);
		@(posedge mclk);
		stage_force_en <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			axi_wr(ADDR_CFG, {22'h0, 2'(c), 8'h00}, RESP_OKAY);
			repeat (4) @(negedge mclk);
			outs({c == 3, c == 2, c == 1 || c == 2});
		end
		axi_wr(ADDR_CFG, 32'h0000_0400, RESP_OKAY);
		feed(3'h0, 16'h0015, 1'b0);
		ticks(2);
		outs(3'b100);
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		stage_force_en <= 1'b0;
		rst <= 1'b0;
		axi_rd(ADDR_CFG, RESP_OKAY, d);
		chk("cfg_rst", 32'h0000_0000, d);
		axi_rd(ADDR_OP_DLY, RESP_OKAY, d);
		chk("op_dly_rst", 32'h0000_0014, d);
		outs(3'b000);
		test_done();
	end

	// Run needs about 8000 cycles
	initial begin
		repeat (60000) @(posedge mclk);
		errors++;
		test_done();
	end
endmodule
`default_nettype wire
